// File: eiec_ctrl.sv
// Purpose: Edge interrupt/event controller with 19 lines behind an Avalon-MM slave.
// Assumes: Pins and internal sources are asynchronous; pin select comes from same clock.
// Notes:   Interrupt outputs lag the pending flags by one clock.
//
// Notes on behaviour
// R1: Nineteen lines, each with its own trigger, interrupt and event enables.
// R2: Rising enable catches rising edges, falling enable falling; both catch either.
// R3: Lines 0-15 take pin n of the port chosen by the line source select.
// R4: Line 16 is low-voltage detect, 17 calendar alarm, 18 USB wakeup.
// R5: Enabled edge sets pending if interrupt enabled; event raised without pending.
// R6: Setting a soft trigger bit raises interrupt or event at once, per enables.
// R7: Software clears a pending flag by writing one; it stays set until then.
// R8: Software selects sources, then edge enables, then interrupt or event enables.
// R9: Interrupts and events also go to the wakeup logic.
// R10: Calendar alarm and USB wakeup lines have their own interrupt requests.
// R11: Lines 5-9 share one request and lines 10-15 another.
// R12: Interrupt enable one permits, zero blocks; all enables reset to zero.
// R13: Rising enable zero makes a rising edge be ignored.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "eiec_params.svh"
module eiec_ctrl (
  input  wire logic                                core_clk_i,
  input  wire logic                                rst_n_i,
  input  wire logic [`EIEC_ADDR_W-1:0]             avs_address_i,
  input  wire logic                                avs_read_i,
  input  wire logic                                avs_write_i,
  input  wire logic [31:0]                         avs_writedata_i,
  output logic      [31:0]                         avs_readdata_o,
  output logic                                     avs_waitrequest_o,
  input  wire logic [`EIEC_NPORTS*`EIEC_NGPIO-1:0] gpio_pins_i,
  input  wire logic [`EIEC_NGPIO*`EIEC_SEL_W-1:0]  line_source_select_i,
  input  wire logic                                low_voltage_detect_i,
  input  wire logic                                cal_alarm_i,
  input  wire logic                                usb_wakeup_i,
  output logic      [4:0]                          irq_line_4_0_o,
  output logic                                     irq_low_volt_o,
  output logic                                     irq_grp_9_5_o,
  output logic                                     irq_grp_15_10_o,
  output logic                                     irq_alarm_o,
  output logic                                     irq_usb_wake_o,
  output logic                                     irq_o,
  output logic      [`EIEC_NLINES-1:0]             event_lines_o,
  output logic                                     event_o,
  output logic                                     wakeup_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NRAW = `EIEC_NPORTS*`EIEC_NGPIO + 3;
  logic [NRAW-1:0] sync1_ff;
  logic [NRAW-1:0] sync2_ff;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {usb_wakeup_i, cal_alarm_i, low_voltage_detect_i, gpio_pins_i};
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Source routing
  // ----------------------------------------------------------------
  // Changing a line's source while its edge enables are set may look like an edge,
  // which is why software selects sources before enabling triggers.
  eiec_pkg::eiec_line_t line_raw;
  genvar gi;
  generate
    for (gi = 0; gi < `EIEC_NGPIO; gi++) begin : g_src
      wire eiec_pkg::eiec_sel_t sel = line_source_select_i[gi*`EIEC_SEL_W +: `EIEC_SEL_W];
      assign line_raw[gi] = (sel < `EIEC_NPORTS) ? sync2_ff[sel*`EIEC_NGPIO + gi] : 1'b0; // R3
    end
  endgenerate
  assign line_raw[`EIEC_LINE_LOWV]  = sync2_ff[NRAW-3]; // R4
  assign line_raw[`EIEC_LINE_ALARM] = sync2_ff[NRAW-2]; // R4
  assign line_raw[`EIEC_LINE_USBWK] = sync2_ff[NRAW-1]; // R4

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  eiec_pkg::eiec_line_t inten_ff;
  eiec_pkg::eiec_line_t even_ff;
  eiec_pkg::eiec_line_t rise_en_ff;
  eiec_pkg::eiec_line_t fall_en_ff;
  eiec_pkg::eiec_line_t soft_ff;
  eiec_pkg::eiec_line_t pend_ff;
  eiec_pkg::eiec_line_t prev_ff;
  logic                 wait_ff;
  logic [31:0]          rdata_ff;
  eiec_pkg::eiec_reg_t  reg_sel;

  assign reg_sel = (avs_address_i == `EIEC_OFS_INTEN) ? eiec_pkg::EIEC_REG_INTEN :
                   (avs_address_i == `EIEC_OFS_EVEN)  ? eiec_pkg::EIEC_REG_EVEN  :
                   (avs_address_i == `EIEC_OFS_RISE)  ? eiec_pkg::EIEC_REG_RISE  :
                   (avs_address_i == `EIEC_OFS_FALL)  ? eiec_pkg::EIEC_REG_FALL  :
                   (avs_address_i == `EIEC_OFS_SOFT)  ? eiec_pkg::EIEC_REG_SOFT  :
                   (avs_address_i == `EIEC_OFS_PEND)  ? eiec_pkg::EIEC_REG_PEND  :
                                                        eiec_pkg::EIEC_REG_NONE;

  // A request is answered one clock after it appears; the write lands on the answer edge.
  wire                 req      = avs_read_i | avs_write_i;
  wire                 wr_fire  = avs_write_i & ~wait_ff;
  wire eiec_pkg::eiec_line_t wdat = avs_writedata_i[`EIEC_NLINES-1:0];
  wire wr_inten = wr_fire & (reg_sel == eiec_pkg::EIEC_REG_INTEN);
  wire wr_even  = wr_fire & (reg_sel == eiec_pkg::EIEC_REG_EVEN);
  wire wr_rise  = wr_fire & (reg_sel == eiec_pkg::EIEC_REG_RISE);
  wire wr_fall  = wr_fire & (reg_sel == eiec_pkg::EIEC_REG_FALL);
  wire wr_soft  = wr_fire & (reg_sel == eiec_pkg::EIEC_REG_SOFT);
  wire wr_pend  = wr_fire & (reg_sel == eiec_pkg::EIEC_REG_PEND);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_sel)
      eiec_pkg::EIEC_REG_INTEN: rd_mux[`EIEC_NLINES-1:0] = inten_ff;
      eiec_pkg::EIEC_REG_EVEN:  rd_mux[`EIEC_NLINES-1:0] = even_ff;
      eiec_pkg::EIEC_REG_RISE:  rd_mux[`EIEC_NLINES-1:0] = rise_en_ff;
      eiec_pkg::EIEC_REG_FALL:  rd_mux[`EIEC_NLINES-1:0] = fall_en_ff;
      eiec_pkg::EIEC_REG_SOFT:  rd_mux[`EIEC_NLINES-1:0] = soft_ff;
      eiec_pkg::EIEC_REG_PEND:  rd_mux[`EIEC_NLINES-1:0] = pend_ff;
      default:                  rd_mux = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Edge detection and triggers
  // ----------------------------------------------------------------
  wire eiec_pkg::eiec_line_t rise_v   = line_raw & ~prev_ff;
  wire eiec_pkg::eiec_line_t fall_v   = ~line_raw & prev_ff;
  wire eiec_pkg::eiec_line_t hw_trig  = (rise_v & rise_en_ff) | (fall_v & fall_en_ff); // R2 R13
  wire eiec_pkg::eiec_line_t sw_trig  = wr_soft ? (wdat & ~soft_ff) : '0; // R6
  wire eiec_pkg::eiec_line_t trig     = hw_trig | sw_trig;
  wire eiec_pkg::eiec_line_t pend_set = trig & inten_ff; // R5 R12
  wire eiec_pkg::eiec_line_t pend_clr = wr_pend ? wdat : '0; // R7
  wire eiec_pkg::eiec_line_t evt_v    = trig & even_ff; // R5

  // A new trigger in the same clock as its clear keeps the flag set.
  wire eiec_pkg::eiec_line_t nxt_pend  = (pend_ff & ~pend_clr) | pend_set;
  // Clearing a pending flag also rearms its soft trigger bit.
  wire eiec_pkg::eiec_line_t nxt_soft  = wr_soft ? wdat : (soft_ff & ~pend_clr);
  wire eiec_pkg::eiec_line_t irq_v     = pend_ff & inten_ff;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inten_ff <= `EIEC_LINE_RST; // R12
      even_ff  <= `EIEC_LINE_RST;
      rise_en_ff <= `EIEC_LINE_RST;
      fall_en_ff <= `EIEC_LINE_RST;
      soft_ff    <= `EIEC_LINE_RST;
      pend_ff  <= `EIEC_LINE_RST;
      prev_ff  <= `EIEC_LINE_RST;
    end else begin
      if (wr_inten) inten_ff <= wdat; // R1
      if (wr_even)  even_ff  <= wdat;
      if (wr_rise)  rise_en_ff <= wdat;
      if (wr_fall)  fall_en_ff <= wdat;
      soft_ff  <= nxt_soft;
      pend_ff  <= nxt_pend;
      prev_ff  <= line_raw;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff  <= ~(req & wait_ff);
      rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_line_4_0_o  <= 5'h00;
      irq_low_volt_o  <= 1'b0;
      irq_grp_9_5_o   <= 1'b0;
      irq_grp_15_10_o <= 1'b0;
      irq_alarm_o     <= 1'b0;
      irq_usb_wake_o  <= 1'b0;
      irq_o           <= 1'b0;
      event_lines_o   <= `EIEC_LINE_RST;
      event_o         <= 1'b0;
      wakeup_o        <= 1'b0;
    end else begin
      irq_line_4_0_o  <= irq_v[4:0];
      irq_low_volt_o  <= irq_v[`EIEC_LINE_LOWV];
      irq_grp_9_5_o   <= |irq_v[9:5]; // R11
      irq_grp_15_10_o <= |irq_v[15:10]; // R11
      irq_alarm_o     <= irq_v[`EIEC_LINE_ALARM]; // R10
      irq_usb_wake_o  <= irq_v[`EIEC_LINE_USBWK]; // R10
      irq_o           <= |irq_v;
      event_lines_o   <= evt_v;
      event_o         <= |evt_v;
      wakeup_o        <= (|irq_v) | (|evt_v); // R9
    end
  end

  assign avs_waitrequest_o = wait_ff;
  assign avs_readdata_o    = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_line_set;
    |pend_set;
  endsequence
  sequence s_flag_up;
    (pend_ff & $past(pend_set)) == $past(pend_set);
  endsequence

  property p_pend_set;
    s_line_set |=> s_flag_up;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending flag not set"); // R5

  property p_evt_out;
    1'b1 |=> (event_lines_o == $past(trig & even_ff));
  endproperty
  a_evt_out: assert property (p_evt_out) else $error("event output wrong"); // R5

  property p_blocked;
    1'b1 |=> ((pend_ff & ~$past(pend_ff) & ~$past(inten_ff)) == '0);
  endproperty
  a_blocked: assert property (p_blocked) else $error("disabled line set pending"); // R12

  property p_rise_only;
    1'b1 |=> (pend_ff & ~$past(pend_ff) &
              ~(($past(line_raw) & ~$past(line_raw, 2) & $past(rise_en_ff)) |
                (~$past(line_raw) & $past(line_raw, 2) & $past(fall_en_ff)) |
                $past(sw_trig))) == '0;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("edge select wrong"); // R2 R13

  property p_soft;
    |(sw_trig & inten_ff) |=> ##1 ((irq_v & $past(sw_trig & inten_ff, 2)) != '0);
  endproperty
  a_soft: assert property (p_soft) else $error("soft trigger lost"); // R6

  property p_src_lowv;
    line_raw[`EIEC_LINE_LOWV] == $past(low_voltage_detect_i, 2);
  endproperty
  a_src_lowv: assert property (p_src_lowv) else $error("line 16 source wrong"); // R4

  property p_src_usb;
    line_raw[`EIEC_LINE_USBWK] == $past(usb_wakeup_i, 2);
  endproperty
  a_src_usb: assert property (p_src_usb) else $error("line 18 source wrong"); // R4

  property p_alarm;
    irq_v[`EIEC_LINE_ALARM] |=> irq_alarm_o && irq_o && wakeup_o;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm request missing"); // R10 R9

  property p_grp;
    1'b1 |=> (irq_grp_9_5_o == $past(|irq_v[9:5])) &&
             (irq_grp_15_10_o == $past(|irq_v[15:10]));
  endproperty
  a_grp: assert property (p_grp) else $error("shared request wrong"); // R11

  property p_line_out;
    1'b1 |=> (irq_line_4_0_o == $past(irq_v[4:0])) &&
             (irq_low_volt_o == $past(irq_v[`EIEC_LINE_LOWV]));
  endproperty
  a_line_out: assert property (p_line_out) else $error("per line request wrong"); // R1 R4

  property p_wake;
    1'b1 |=> (wakeup_o == ($past(|irq_v) || $past(|evt_v))) && (irq_o == $past(|irq_v));
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup or summary request wrong"); // R9

  property p_usb;
    irq_v[`EIEC_LINE_USBWK] |=> irq_usb_wake_o && irq_o && wakeup_o;
  endproperty
  a_usb: assert property (p_usb) else $error("usb wakeup request missing"); // R10 R9

  property p_ev_clean;
    (trig & even_ff) == '0 |=> !event_o && (event_lines_o == '0);
  endproperty
  a_ev_clean: assert property (p_ev_clean) else $error("event without trigger"); // R5

  // An enabled edge on an enabled line must leave its flag set one clock later.
  property p_edge_set;
    1'b1 |=> (~pend_ff & $past(inten_ff) &
              (($past(line_raw) & ~$past(line_raw, 2) & $past(rise_en_ff)) |
               (~$past(line_raw) & $past(line_raw, 2) & $past(fall_en_ff)))) == '0;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("enabled edge lost"); // R2 R5

  property p_sel_off;
    line_source_select_i[11:9] > 3'h4 |-> !line_raw[3];
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("unused select code passes a pin"); // R3

  property p_hold;
    (|pend_ff) && !wr_pend |=> (pend_ff & $past(pend_ff)) == $past(pend_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("pending flag dropped"); // R1 R7

endmodule : eiec_ctrl

// File: eiec_params.svh
// Purpose: Offsets, field widths, reset values for the edge interrupt/event controller.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes:   Definitions only.
`ifndef EIEC_PARAMS_SVH
`define EIEC_PARAMS_SVH
`define EIEC_NLINES      19
`define EIEC_NGPIO       16
`define EIEC_NPORTS      5
`define EIEC_SEL_W       3
`define EIEC_ADDR_W      8
`define EIEC_OFS_INTEN   8'h00
`define EIEC_OFS_EVEN    8'h04
`define EIEC_OFS_RISE    8'h08
`define EIEC_OFS_FALL    8'h0C
`define EIEC_OFS_SOFT    8'h10
`define EIEC_OFS_PEND    8'h14
`define EIEC_LINE_RST    19'h00000
`define EIEC_LINE_LOWV   16
`define EIEC_LINE_ALARM  17
`define EIEC_LINE_USBWK  18
`endif

// File: eiec_pkg.sv
// Purpose: Types shared by the edge interrupt/event controller.
// Assumes: Constants come from eiec_params.svh.
// Notes:   Types only.
`include "eiec_params.svh"
package eiec_pkg;
  typedef logic [`EIEC_NLINES-1:0] eiec_line_t;
  typedef logic [`EIEC_SEL_W-1:0]  eiec_sel_t;
  typedef enum logic [2:0] {
    EIEC_REG_INTEN,
    EIEC_REG_EVEN,
    EIEC_REG_RISE,
    EIEC_REG_FALL,
    EIEC_REG_SOFT,
    EIEC_REG_PEND,
    EIEC_REG_NONE
  } eiec_reg_t;
endpackage : eiec_pkg

// File: eiec_cpu_sink.sv
// Purpose: Far-side model that takes the event and wakeup outputs.
// Assumes: Event pulses last one clock; wakeup is a level or a pulse.
// Notes:   Counts only, so the bench can judge pulse widths and wake requests.
`timescale 1ns/1ps
module eiec_cpu_sink (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       event_i,
  input  wire logic       wakeup_i,
  output logic      [7:0] ev_cnt_o,
  output logic      [7:0] wk_cnt_o
);
  logic wk_prev_ff;
  // Every high event cycle counts, so a pulse that stretches shows as an extra event; wakeup counts rising edges.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_cnt_o   <= 8'h00;
      wk_cnt_o   <= 8'h00;
      wk_prev_ff <= 1'b0;
    end else begin
      ev_cnt_o   <= ev_cnt_o + {7'h00, event_i};
      wk_cnt_o   <= wk_cnt_o + {7'h00, wakeup_i & ~wk_prev_ff};
      wk_prev_ff <= wakeup_i;
    end
  end
endmodule : eiec_cpu_sink

// File: testbench.sv
// Purpose: Self-checking bench for the edge interrupt and event controller.
// Assumes: One wait cycle per bus access; pin to interrupt within 8 clocks.
// Notes:   Software order is kept: sources, then edges, then enables.
`timescale 1ns/1ps
`include "eiec_params.svh"
module testbench;
  logic                                core_clk_i;
  logic                                rst_n_i;
  logic [`EIEC_ADDR_W-1:0]             avs_address_i;
  logic                                avs_read_i;
  logic                                avs_write_i;
  logic [31:0]                         avs_writedata_i;
  logic [31:0]                         avs_readdata_o;
  logic                                avs_waitrequest_o;
  logic [`EIEC_NPORTS*`EIEC_NGPIO-1:0] gpio_pins_i;
  logic [`EIEC_NGPIO*`EIEC_SEL_W-1:0]  line_source_select_i;
  logic                                low_voltage_detect_i;
  logic                                cal_alarm_i;
  logic                                usb_wakeup_i;
  logic [4:0]                          irq_line_4_0_o;
  logic                                irq_low_volt_o;
  logic                                irq_grp_9_5_o;
  logic                                irq_grp_15_10_o;
  logic                                irq_alarm_o;
  logic                                irq_usb_wake_o;
  logic                                irq_o;
  logic [`EIEC_NLINES-1:0]             event_lines_o;
  logic                                event_o;
  logic                                wakeup_o;
  logic [7:0]                          ev_cnt;
  logic [7:0]                          wk_cnt;
  logic [31:0]                         rd;
  logic [`EIEC_NLINES-1:0]             ev_seen;
  int                                  mismatches;
  int                                  tests_run;
  int                                  cycles;

  eiec_ctrl DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .gpio_pins_i(gpio_pins_i), .line_source_select_i(line_source_select_i),
    .low_voltage_detect_i(low_voltage_detect_i), .cal_alarm_i(cal_alarm_i),
    .usb_wakeup_i(usb_wakeup_i), .irq_line_4_0_o(irq_line_4_0_o),
    .irq_low_volt_o(irq_low_volt_o),
    .irq_grp_9_5_o(irq_grp_9_5_o), .irq_grp_15_10_o(irq_grp_15_10_o),
    .irq_alarm_o(irq_alarm_o), .irq_usb_wake_o(irq_usb_wake_o), .irq_o(irq_o),
    .event_lines_o(event_lines_o), .event_o(event_o), .wakeup_o(wakeup_o));
  eiec_cpu_sink sink (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .event_i(event_o),
    .wakeup_i(wakeup_o), .ev_cnt_o(ev_cnt), .wk_cnt_o(wk_cnt));

  always #2 core_clk_i = ~core_clk_i;
  // The per-line event word stands for one clock only, so it is latched on each pulse.
  always @(posedge core_clk_i) begin
    if (event_o) begin
      ev_seen <= event_lines_o;
    end
  end
  // A hung handshake would otherwise stall the run for ever.
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // The leading edge keeps a new request off the edge that released the last one.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    avs_writedata_i <= d;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task automatic clk(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : clk

  task automatic t_reset();
    for (int a = 0; a <= 8'h18; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      cmp(rd, 32'h0);
    end
    bus(1'b1, 8'h18, 32'hFFFFFFFF);
    bus(1'b0, 8'h00, 32'h0);
    cmp(rd, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_soft();
    bus(1'b1, 8'h00, 32'h00020000);
    bus(1'b1, 8'h10, 32'h00020000);
    clk(2);
    cmp({30'h0, irq_alarm_o, irq_o}, 32'h3);
    bus(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h00020000);
    bus(1'b1, 8'h14, 32'h00020000);
    bus(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h0);
    clk(2);
    cmp({31'h0, irq_o}, 32'h0);
    $display("test soft trigger done");
  endtask : t_soft

  task automatic t_gpio();
    line_source_select_i[23:21] <= 3'h2;
    bus(1'b1, 8'h08, 32'h00000080);
    bus(1'b1, 8'h0C, 32'h00001000);
    bus(1'b1, 8'h00, 32'h00001080);
    gpio_pins_i[39] <= 1'b1;
    gpio_pins_i[12] <= 1'b1;
    clk(8);
    cmp({30'h0, irq_grp_9_5_o, irq_grp_15_10_o}, 32'h2);
    bus(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h00000080);
    gpio_pins_i[39] <= 1'b0;
    gpio_pins_i[12] <= 1'b0;
    clk(8);
    bus(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h00001080);
    cmp({31'h0, irq_grp_15_10_o}, 32'h1);
    bus(1'b1, 8'h14, 32'h00001080);
    bus(1'b1, 8'h00, 32'h0);
    $display("test gpio done");
  endtask : t_gpio

  task automatic t_event();
    logic [7:0] e0;
    logic [7:0] w0;
    bus(1'b1, 8'h08, 32'h00010000);
    bus(1'b1, 8'h04, 32'h00010000);
    e0 = ev_cnt;
    w0 = wk_cnt;
    low_voltage_detect_i <= 1'b1;
    clk(8);
    cmp({24'h0, ev_cnt - e0}, 32'h1);
    cmp({24'h0, wk_cnt - w0}, 32'h1);
    cmp({13'h0, ev_seen}, 32'h00010000);
    bus(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h0);
    cmp({31'h0, irq_low_volt_o}, 32'h0);
    $display("test event done");
  endtask : t_event

  task automatic t_usb();
    bus(1'b1, 8'h0C, 32'h00040000);
    bus(1'b1, 8'h00, 32'h00040000);
    usb_wakeup_i <= 1'b1;
    clk(8);
    usb_wakeup_i <= 1'b0;
    clk(8);
    cmp({31'h0, irq_usb_wake_o}, 32'h1);
    bus(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h00040000);
    $display("test usb wakeup done");
  endtask : t_usb

  task automatic t_both();
    bus(1'b1, 8'h14, 32'h00040000);
    line_source_select_i[11:9] <= 3'h4;
    bus(1'b1, 8'h08, 32'h00000008);
    bus(1'b1, 8'h0C, 32'h00000008);
    bus(1'b1, 8'h00, 32'h00000008);
    bus(1'b1, 8'h04, 32'h00000008);
    gpio_pins_i[67] <= 1'b1;
    clk(8);
    cmp({27'h0, irq_line_4_0_o}, 32'h8);
    cmp({13'h0, ev_seen}, 32'h8);
    bus(1'b1, 8'h14, 32'h00000008);
    gpio_pins_i[67] <= 1'b0;
    clk(8);
    bus(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h00000008);
    bus(1'b1, 8'h14, 32'h00000008);
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h0C, 32'h0);
    line_source_select_i[11:9] <= 3'h5;
    bus(1'b1, 8'h08, 32'h00000008);
    gpio_pins_i[67] <= 1'b1;
    clk(8);
    bus(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h0);
    cmp({27'h0, irq_line_4_0_o}, 32'h0);
    $display("test both edges done");
  endtask : t_both

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    {core_clk_i, avs_read_i, avs_write_i, low_voltage_detect_i} = 4'h0;
    {cal_alarm_i, usb_wakeup_i, rst_n_i} = 3'h0;
    {avs_address_i, avs_writedata_i, gpio_pins_i, line_source_select_i} = '0;
    {mismatches, tests_run, cycles} = '0;
    clk(2);
    rst_n_i <= 1'b1;
    t_reset();
    t_soft();
    t_gpio();
    t_event();
    t_usb();
    t_both();
    report_and_stop();
  end
endmodule : testbench
